// ### design/asr_pkg.sv
// package for the acceleration status and result registers
// assumes: shared by the register block and its serial link
package asr_pkg;

  // register offsets
  localparam logic [7:0] STRAP_OFS = 8'h00;
  localparam logic [7:0] COND_OFS = 8'h01;
  localparam logic [7:0] X_LOW_OFS = 8'h02;
  localparam logic [7:0] X_HIGH_OFS = 8'h03;
  localparam logic [7:0] Y_LOW_OFS = 8'h04;
  localparam logic [7:0] Y_HIGH_OFS = 8'h05;
  localparam logic [7:0] Z_LOW_OFS = 8'h06;
  localparam logic [7:0] Z_HIGH_OFS = 8'h07;
  localparam int REG_COUNT = 8;

  // field positions
  localparam int STRAP_BIT = 3;
  localparam int OVR_BIT = 0;
  localparam int CLKGATE_BIT = 1;
  localparam int FUSE_BIT = 5;
  localparam int WATCH_BIT = 6;
  localparam int ACT_BIT = 7;
  localparam int SPI_RW_BIT = 7;

  // reset values
  localparam logic [7:0] STRAP_RESET = 8'h00;
  localparam logic [7:0] COND_RESET = 8'h04;

  // two-wire target addresses, chosen by the strap
  localparam logic [6:0] BUS_ADDR_LOW = 7'h4C;
  localparam logic [6:0] BUS_ADDR_HIGH = 7'h6C;

  // continuous sampling mode code
  localparam logic [2:0] MODE_CONT = 3'b101;

  // result widths and strap settling count
  localparam int RESULT_BITS = 14;
  localparam int FIFO_BITS = 12;
  localparam logic [1:0] STRAP_SETTLE = 2'h2;

  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
  } asr_axes_t;

  typedef struct packed {
    logic clkGated;
    logic fuseOn;
    logic watchActive;
  } asr_cond_t;

  typedef logic [REG_COUNT-1:0][7:0] asr_image_t;

  typedef enum logic [2:0] {
    I_IDLE = 3'b000,
    I_ADDR = 3'b001,
    I_AACK = 3'b010,
    I_RXB = 3'b011,
    I_RACK = 3'b100,
    I_TXB = 3'b101,
    I_TACK = 3'b110
  } asr_i2c_st_t;

  // register read decode; unmapped offsets read zero
  function automatic logic [7:0] pickByte(input asr_image_t img, input logic [7:0] ofs);
    logic [7:0] r;
    r = 8'h00;
    if (ofs < 8'(REG_COUNT)) begin
      r = img[ofs[2:0]];
    end
    return r;
  endfunction : pickByte

endpackage : asr_pkg

// ### design/asr_spi_link.sv
// four-wire serial slave on the link clock, mode 0
// assumes: register image is held still by the core while select is low
`timescale 1ns/100ps
`default_nettype none
module asr_spi_link (
  input wire logic spiClk,
  input wire logic spiSelN,
  input wire logic spiMosi,
  input wire asr_pkg::asr_image_t regImage,
  output logic spiMiso,
  output logic spiMisoOe,
  output logic entryDone
);

  logic [2:0] bitCnt_ff;
  logic [6:0] sh_ff;
  logic haveCmd_ff;
  logic isRead_ff;
  logic [7:0] addr_ff;
  logic seq_ff;
  logic done_ff;
  logic miso_ff;
  logic [7:0] curByte;

  assign curByte = asr_pkg::pickByte(regImage, addr_ff);

  ////////////////////////////////////////////////////////////////////////
  // command and read tracking; frame end clears all
  always_ff @(posedge spiClk or posedge spiSelN) begin
    if (spiSelN) begin
      bitCnt_ff <= 3'h0;
      sh_ff <= 7'h00;
      haveCmd_ff <= 1'b0;
      isRead_ff <= 1'b0;
      addr_ff <= 8'h00;
      seq_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      sh_ff <= {sh_ff[5:0], spiMosi};
      bitCnt_ff <= bitCnt_ff + 3'h1;
      if (bitCnt_ff == 3'h7) begin
        if (!haveCmd_ff) begin
          haveCmd_ff <= 1'b1;
          isRead_ff <= sh_ff[asr_pkg::SPI_RW_BIT-1];
          addr_ff <= {2'h0, sh_ff[4:0], spiMosi};
        end else begin
          // RQ15: writes are dropped
          addr_ff <= addr_ff + 8'h01;
          // RQ11: full entry read
          if (isRead_ff && addr_ff == asr_pkg::X_LOW_OFS) begin
            seq_ff <= 1'b1;
          end else if (isRead_ff && seq_ff && addr_ff == asr_pkg::Z_HIGH_OFS) begin
            done_ff <= 1'b1;
          end
        end
      end
    end
  end

  // read data shifts out on the falling edge
  always_ff @(negedge spiClk or posedge spiSelN) begin
    if (spiSelN) begin
      miso_ff <= 1'b0;
    end else begin
      miso_ff <= (haveCmd_ff && isRead_ff) ? curByte[~bitCnt_ff] : 1'b0;
    end
  end

  assign spiMiso = miso_ff;
  assign spiMisoOe = !spiSelN;
  assign entryDone = done_ff;

endmodule : asr_spi_link
`default_nettype wire

// ### design/asr_status_regs.sv
// status and acceleration result registers with two serial ports
// assumes: sample, fifo head and condition inputs are on clk;
// the pins and the four-wire link clock come from outside.
// How it works
// RQ1: strap caught after reset picks target address
// RQ2: replaced unread sample sets overrun flag
// RQ3: clock gated state shows in bit 1
// RQ4: fuse supply state shows in bit 5
// RQ5: activity watch running shows in bit 6
// RQ6: activity event flags and requests continuous mode
// RQ7: results sign-extended to sixteen bits
// RQ8: host selects exactly one serial port
// RQ9: no port selected means no result updates
// RQ10: fifo head shown at twelve bit resolution
// RQ11: full six-byte read advances fifo pointer
// RQ12: two-wire transaction freezes all registers
// RQ13: host reads byte pairs in one transaction
// RQ14: continuous sampling mode code is 101
// RQ15: reads side-effect free, writes ignored
`timescale 1ns/100ps
`default_nettype none
module asr_status_regs #(
  parameter int RESULT_BITS = asr_pkg::RESULT_BITS,
  parameter int FIFO_BITS = asr_pkg::FIFO_BITS
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic addrStrapPin,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic spiClk,
  input wire logic spiSelN,
  input wire logic spiMosi,
  output logic spiMiso,
  output logic spiMisoOe,
  input wire logic twoWireEn,
  input wire logic spiEn,
  input wire logic fifoEn,
  input wire logic sampleValid,
  input wire asr_pkg::asr_axes_t sampleIn,
  input wire asr_pkg::asr_axes_t fifoHead,
  output logic fifoAdvance,
  input wire asr_pkg::asr_cond_t condIn,
  input wire logic activityEvent,
  output logic modeReqValid,
  output logic [2:0] modeReqCode
);

  // sign extension from a given result width
  function automatic logic [15:0] sext(input logic [15:0] raw, input int bits);
    logic [15:0] v;
    v = raw;
    for (int i = 0; i < 16; i++) begin
      if (i >= bits) begin
        v[i] = raw[bits-1];
      end
    end
    return v;
  endfunction : sext

  function automatic asr_pkg::asr_axes_t sextAxes(input asr_pkg::asr_axes_t a, input int bits);
    asr_pkg::asr_axes_t r;
    r.x = sext(a.x, bits);
    r.y = sext(a.y, bits);
    r.z = sext(a.z, bits);
    return r;
  endfunction : sextAxes

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic strapS;
  logic sclS;
  logic sdaS;
  logic spiSelS;
  logic spiDoneS;
  logic spiDone;

  asr_sync2 #(
    .WIDTH(5),
    .RST_VAL(5'h0E)
  ) pinSync (
    .clk(clk),
    .sys_rst(sys_rst),
    .din({spiDone, spiSelN, sclIn, sdaIn, addrStrapPin}),
    .dout({spiDoneS, spiSelS, sclS, sdaS, strapS})
  );

  ////////////////////////////////////////////////////////////////////////
  // strap capture after reset release
  logic [1:0] settleCnt_ff;
  logic strapTaken_ff;
  logic strapBit_ff;
  logic [6:0] ownAddr;

  // RQ1: strap capture
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      settleCnt_ff <= 2'h0;
      strapTaken_ff <= 1'b0;
      strapBit_ff <= 1'b0;
    end else if (!strapTaken_ff) begin
      if (settleCnt_ff == asr_pkg::STRAP_SETTLE) begin
        strapBit_ff <= strapS;
        strapTaken_ff <= 1'b1;
      end else begin
        settleCnt_ff <= settleCnt_ff + 2'h1;
      end
    end
  end

  // RQ1: address select
  assign ownAddr = strapBit_ff ? asr_pkg::BUS_ADDR_HIGH : asr_pkg::BUS_ADDR_LOW;

  ////////////////////////////////////////////////////////////////////////
  // two-wire slave, oversampled on clk
  logic sclPrev_ff;
  logic sdaPrev_ff;
  logic startCond;
  logic stopCond;
  logic sclRise;
  logic sclFall;
  asr_pkg::asr_i2c_st_t i2cSt_ff;
  logic [2:0] bitCnt_ff;
  logic [7:0] rxSh_ff;
  logic [7:0] txSh_ff;
  logic [7:0] ptr_ff;
  logic ptrSet_ff;
  logic rdMode_ff;
  logic ackOk_ff;
  logic byteIn_ff;
  logic busy_ff;
  asr_pkg::asr_image_t image;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sclPrev_ff <= 1'b1;
      sdaPrev_ff <= 1'b1;
    end else begin
      sclPrev_ff <= sclS;
      sdaPrev_ff <= sdaS;
    end
  end

  // bus conditions from the synchronised lines
  assign startCond = sclS && sclPrev_ff && sdaPrev_ff && !sdaS;
  assign stopCond = sclS && sclPrev_ff && !sdaPrev_ff && sdaS;
  assign sclRise = sclS && !sclPrev_ff;
  assign sclFall = !sclS && sclPrev_ff;

  // byte engine
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      i2cSt_ff <= asr_pkg::I_IDLE;
      bitCnt_ff <= 3'h0;
      rxSh_ff <= 8'h00;
      txSh_ff <= 8'h00;
      ptr_ff <= 8'h00;
      ptrSet_ff <= 1'b0;
      rdMode_ff <= 1'b0;
      ackOk_ff <= 1'b0;
      byteIn_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else if (startCond && twoWireEn && strapTaken_ff) begin
      // RQ12: freeze from start
      i2cSt_ff <= asr_pkg::I_ADDR;
      bitCnt_ff <= 3'h0;
      byteIn_ff <= 1'b0;
      busy_ff <= 1'b1;
    end else if (stopCond) begin
      // RQ12: release at stop
      i2cSt_ff <= asr_pkg::I_IDLE;
      busy_ff <= 1'b0;
    end else begin
      case (i2cSt_ff)
        asr_pkg::I_ADDR, asr_pkg::I_RXB: begin
          if (sclRise) begin
            rxSh_ff <= {rxSh_ff[6:0], sdaS};
            bitCnt_ff <= bitCnt_ff + 3'h1;
            byteIn_ff <= (bitCnt_ff == 3'h7);
          end else if (sclFall && byteIn_ff) begin
            byteIn_ff <= 1'b0;
            if (i2cSt_ff == asr_pkg::I_ADDR) begin
              // RQ1: address match
              if (rxSh_ff[7:1] == ownAddr) begin
                i2cSt_ff <= asr_pkg::I_AACK;
                rdMode_ff <= rxSh_ff[0];
              end else begin
                i2cSt_ff <= asr_pkg::I_IDLE;
              end
            end else begin
              i2cSt_ff <= asr_pkg::I_RACK;
              if (!ptrSet_ff) begin
                ptr_ff <= rxSh_ff;
                ptrSet_ff <= 1'b1;
              end else begin
                // RQ15: write data dropped
                ptr_ff <= ptr_ff + 8'h01;
              end
            end
          end
        end
        asr_pkg::I_AACK: begin
          if (sclFall) begin
            bitCnt_ff <= 3'h0;
            if (rdMode_ff) begin
              i2cSt_ff <= asr_pkg::I_TXB;
              txSh_ff <= asr_pkg::pickByte(image, ptr_ff);
            end else begin
              i2cSt_ff <= asr_pkg::I_RXB;
              ptrSet_ff <= 1'b0;
            end
          end
        end
        asr_pkg::I_RACK: begin
          if (sclFall) begin
            i2cSt_ff <= asr_pkg::I_RXB;
            bitCnt_ff <= 3'h0;
          end
        end
        asr_pkg::I_TXB: begin
          if (sclFall) begin
            txSh_ff <= {txSh_ff[6:0], 1'b0};
            bitCnt_ff <= bitCnt_ff + 3'h1;
            if (bitCnt_ff == 3'h7) begin
              i2cSt_ff <= asr_pkg::I_TACK;
              ptr_ff <= ptr_ff + 8'h01;
            end
          end
        end
        asr_pkg::I_TACK: begin
          if (sclRise) begin
            ackOk_ff <= !sdaS;
          end else if (sclFall) begin
            if (ackOk_ff) begin
              i2cSt_ff <= asr_pkg::I_TXB;
              txSh_ff <= asr_pkg::pickByte(image, ptr_ff);
              bitCnt_ff <= 3'h0;
            end else begin
              i2cSt_ff <= asr_pkg::I_IDLE;
            end
          end
        end
        default: begin
          i2cSt_ff <= asr_pkg::I_IDLE;
        end
      endcase
    end
  end

  // open-drain data line: pulls low for ack and zero bits
  assign sdaOut = 1'b0;
  assign sdaOe = (i2cSt_ff == asr_pkg::I_AACK) || (i2cSt_ff == asr_pkg::I_RACK) ||
                 ((i2cSt_ff == asr_pkg::I_TXB) && !txSh_ff[7]);

  ////////////////////////////////////////////////////////////////////////
  // read-sequence tracking and fifo advance
  logic i2cByteRead;
  logic [7:0] nextExp_ff;
  logic i2cFull;
  logic spiDonePrev_ff;
  logic readDone;
  logic fifoAdv_ff;

  assign i2cByteRead = (i2cSt_ff == asr_pkg::I_TXB) && sclFall && (bitCnt_ff == 3'h7) &&
                       !startCond && !stopCond;

  // RQ11: consecutive reads
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      nextExp_ff <= 8'h00;
    end else if (i2cByteRead) begin
      if (ptr_ff == asr_pkg::X_LOW_OFS) begin
        nextExp_ff <= asr_pkg::X_HIGH_OFS;
      end else if (ptr_ff == nextExp_ff && ptr_ff != asr_pkg::Z_HIGH_OFS) begin
        nextExp_ff <= ptr_ff + 8'h01;
      end else begin
        nextExp_ff <= 8'h00;
      end
    end
  end

  assign i2cFull = i2cByteRead && (ptr_ff == asr_pkg::Z_HIGH_OFS) && (nextExp_ff == asr_pkg::Z_HIGH_OFS);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      spiDonePrev_ff <= 1'b0;
    end else begin
      spiDonePrev_ff <= spiDoneS;
    end
  end

  assign readDone = i2cFull || (spiDoneS && !spiDonePrev_ff && spiEn);

  // RQ11: pointer advance pulse
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fifoAdv_ff <= 1'b0;
    end else begin
      fifoAdv_ff <= readDone && fifoEn;
    end
  end

  assign fifoAdvance = fifoAdv_ff;

  ////////////////////////////////////////////////////////////////////////
  // sample capture, freeze and result registers
  logic frozen;
  logic portOn;
  logic newSample;
  asr_pkg::asr_axes_t pend_ff;
  logic pendValid_ff;
  asr_pkg::asr_axes_t res_ff;
  logic unread_ff;
  logic ovr_ff;

  // RQ12: hold during transactions
  assign frozen = busy_ff || (!spiSelS && spiEn);
  // RQ9: port must be chosen
  assign portOn = twoWireEn || spiEn;
  assign newSample = sampleValid && !fifoEn && portOn;

  // RQ7: sign-extended capture
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pend_ff <= '0;
      pendValid_ff <= 1'b0;
    end else if (newSample) begin
      pend_ff <= sextAxes(sampleIn, RESULT_BITS);
      pendValid_ff <= 1'b1;
    end else if (!frozen) begin
      pendValid_ff <= 1'b0;
    end
  end

  // RQ10: fifo head when enabled
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      res_ff <= '0;
    end else if (!frozen) begin
      if (fifoEn && portOn) begin
        res_ff <= sextAxes(fifoHead, FIFO_BITS);
      end else if (pendValid_ff) begin
        res_ff <= pend_ff;
      end
    end
  end

  // RQ2: overrun on replacement
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      unread_ff <= 1'b0;
      ovr_ff <= 1'b0;
    end else if (newSample) begin
      ovr_ff <= unread_ff && !readDone;
      unread_ff <= 1'b1;
    end else if (readDone) begin
      unread_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // activity flag and mode request
  logic watchPrev_ff;
  logic actFlag_ff;
  logic modeReq_ff;

  // RQ6: set wins over clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      watchPrev_ff <= 1'b0;
      actFlag_ff <= 1'b0;
      modeReq_ff <= 1'b0;
    end else begin
      watchPrev_ff <= condIn.watchActive;
      modeReq_ff <= activityEvent;
      if (activityEvent) begin
        actFlag_ff <= 1'b1;
      end else if (condIn.watchActive && !watchPrev_ff) begin
        actFlag_ff <= 1'b0;
      end
    end
  end

  assign modeReqValid = modeReq_ff;
  // RQ14: continuous mode code
  assign modeReqCode = asr_pkg::MODE_CONT;

  ////////////////////////////////////////////////////////////////////////
  // condition status image
  logic [7:0] condImg_ff;
  logic [7:0] condLive;

  // RQ3: clock gated bit
  always_comb begin
    condLive = asr_pkg::COND_RESET;
    condLive[asr_pkg::OVR_BIT] = ovr_ff;
    condLive[asr_pkg::CLKGATE_BIT] = condIn.clkGated;
    // RQ4: fuse supply bit
    condLive[asr_pkg::FUSE_BIT] = condIn.fuseOn;
    // RQ5: watch active bit
    condLive[asr_pkg::WATCH_BIT] = condIn.watchActive;
    condLive[asr_pkg::ACT_BIT] = actFlag_ff;
  end

  // RQ12: status held too
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      condImg_ff <= asr_pkg::COND_RESET;
    end else if (!frozen) begin
      condImg_ff <= condLive;
    end
  end

  // RQ15: read-only image, no read side effects
  always_comb begin
    image = '0;
    image[asr_pkg::STRAP_OFS[2:0]] = asr_pkg::STRAP_RESET;
    image[asr_pkg::STRAP_OFS[2:0]][asr_pkg::STRAP_BIT] = strapBit_ff;
    image[asr_pkg::COND_OFS[2:0]] = condImg_ff;
    image[asr_pkg::X_LOW_OFS[2:0]] = res_ff.x[7:0];
    image[asr_pkg::X_HIGH_OFS[2:0]] = res_ff.x[15:8];
    image[asr_pkg::Y_LOW_OFS[2:0]] = res_ff.y[7:0];
    image[asr_pkg::Y_HIGH_OFS[2:0]] = res_ff.y[15:8];
    image[asr_pkg::Z_LOW_OFS[2:0]] = res_ff.z[7:0];
    image[asr_pkg::Z_HIGH_OFS[2:0]] = res_ff.z[15:8];
  end

  ////////////////////////////////////////////////////////////////////////
  // four-wire link on its own clock
  asr_spi_link spiLink (
    .spiClk(spiClk),
    .spiSelN(spiSelN),
    .spiMosi(spiMosi),
    .regImage(image),
    .spiMiso(spiMiso),
    .spiMisoOe(spiMisoOe),
    .entryDone(spiDone)
  );

endmodule : asr_status_regs
`default_nettype wire

// ### design/asr_sync2.sv
// two-flop synchroniser for a group of independent levels
// assumes: each bit is a slow level; sync reset to a per-bit value
`timescale 1ns/100ps
`default_nettype none
module asr_sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] hold_ff;

  // first stage feeds only the second
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_ff <= RST_VAL;
      hold_ff <= RST_VAL;
    end else begin
      meta_ff <= din;
      hold_ff <= meta_ff;
    end
  end

  assign dout = hold_ff;

endmodule : asr_sync2
`default_nettype wire

// ### test/asr_spi_host.sv
// host model on the four-wire link, mode 0, 125 ns clock
// assumes: caller spaces frames; link clock runs only inside frames
`timescale 1ns/100ps
`default_nettype none
module asr_spi_host (
  output logic spiClk,
  output logic spiSelN,
  output logic spiMosi,
  input wire logic spiMiso,
  input wire logic spiMisoOe,
  output logic [7:0] rxByte,
  output logic rxStb
);
  // idle link
  initial begin
    spiClk = 1'b0;
    spiSelN = 1'b0;
    spiMosi = 1'b0;
    rxByte = 8'h00;
    rxStb = 1'b0;
    // rising select clears the link logic, which has no other reset
    #1 spiSelN = 1'b1;
  end
  ////////////////////////////////////////////////////////////
  // one byte each way, msb first, sample on rise
  task automatic shift(input logic [7:0] tx);
    for (int i = 7; i >= 0; i--) begin
      spiMosi = tx[i];
      #62.5 spiClk = 1'b1;
      rxByte = {rxByte[6:0], spiMisoOe & spiMiso};
      #62.5 spiClk = 1'b0;
    end
  endtask : shift
  task automatic xfer(input logic [7:0] cmd, input int n, input logic [7:0] wd);
    #37 spiSelN = 1'b0;
    #500;
    shift(cmd);
    for (int k = 0; k < n; k++) begin
      shift(wd);
      if (cmd[7]) begin
        rxStb = 1'b1;
        #10 rxStb = 1'b0;
      end
    end
    #62.5 spiSelN = 1'b1;
    spiMosi = ~spiMosi; // released line does not keep its level
    #250;
  endtask : xfer
endmodule : asr_spi_host
`default_nettype wire

// ### test/asr_status_regs_props.sv
// checker for the status and result register block
// assumes: bound to the top module, all signals on clk
`timescale 1ns/100ps
`default_nettype none
module asr_status_regs_props (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic activityEvent,
  input wire logic modeReqValid,
  input wire logic [2:0] modeReqCode,
  input wire logic fifoEn,
  input wire logic fifoAdvance,
  input wire logic twoWireEn,
  input wire logic sdaOe,
  input wire logic spiSelN,
  input wire logic spiMisoOe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////
  // mode request follows an activity event
  mode_code_a: assert property (modeReqValid |-> modeReqCode == 3'h5)
    else $error("mode code wrong");
  mode_pulse_a: assert property (activityEvent |=> modeReqValid)
    else $error("no mode request after event");
  mode_cause_a: assert property (modeReqValid |-> $past(activityEvent))
    else $error("mode request without event");
  // fifo pop only when enabled, one per entry
  fifo_gate_a: assert property (fifoAdvance |-> $past(fifoEn))
    else $error("fifo pop while fifo off");
  fifo_single_a: assert property (fifoAdvance |=> !fifoAdvance [*8])
    else $error("fifo pop repeated");
  rst_quiet_a: assert property ($fell(sys_rst) |-> !fifoAdvance && !modeReqValid && !sdaOe)
    else $error("outputs active after reset");
  // unselected two-wire port stays silent; link output enable follows select
  no_ack_a: assert property (!twoWireEn && !$past(twoWireEn, 4) |-> !sdaOe)
    else $error("two-wire port drives while off");
  oe_sel_a: assert property (spiMisoOe == !spiSelN)
    else $error("link output enable wrong");
  ////////////////////////////////////////////////////////////
  // main scenarios reached
  cover property (modeReqValid);
  cover property (fifoAdvance);
  cover property ($fell(spiSelN));
endmodule : asr_status_regs_props
bind asr_status_regs asr_status_regs_props chk (.clk, .sys_rst, .activityEvent, .modeReqValid,
  .modeReqCode, .fifoEn, .fifoAdvance, .twoWireEn, .sdaOe, .spiSelN, .spiMisoOe);
`default_nettype wire

// ### test/asr_status_regs_tb_top.sv
// testbench for the status and result registers over both serial ports
// assumes: host model on the link, bench drives the pulled-up two-wire bus
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin samplesChecked++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module asr_status_regs_tb_top;
  logic clk, sys_rst, addrStrapPin, twoWireEn, spiEn, fifoEn, sampleValid, activityEvent;
  logic spiClk, spiSelN, spiMosi, spiMiso, spiMisoOe, sdaOut, sdaOe, fifoAdvance;
  logic modeReqValid, rxStb, ack, scl = 1'b1, sdaM = 1'b1, twStb = 1'b0;
  logic [2:0] modeReqCode;
  logic [7:0] rxByte, e, twRx;
  logic [7:0] expQ[$];
  asr_pkg::asr_axes_t sampleIn, fifoHead, a, b, h;
  asr_pkg::asr_cond_t condIn;
  int errors = 0, samplesChecked = 0, seed = 36089, advCount = 0, a0;
  ////////////////////////////////////////////////////////////
  asr_status_regs uut (.clk, .sys_rst, .addrStrapPin, .sclIn(scl), .sdaIn(sdaM && !sdaOe), .sdaOut,
    .sdaOe, .spiClk, .spiSelN, .spiMosi, .spiMiso, .spiMisoOe, .twoWireEn, .spiEn, .fifoEn,
    .sampleValid, .sampleIn, .fifoHead, .fifoAdvance, .condIn, .activityEvent, .modeReqValid,
    .modeReqCode);
  asr_spi_host host (.spiClk, .spiSelN, .spiMosi, .spiMiso, .spiMisoOe, .rxByte, .rxStb);
  // clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // count fifo pops
  always @(posedge clk) begin
    if (fifoAdvance === 1'b1) advCount <= advCount + 1;
  end
  // returned bytes against oldest note
  initial forever begin
    @(posedge rxStb or posedge twStb);
    e = expQ.pop_front();
    `CHK(twStb ? twRx : rxByte, e)
  end
  // hang guard
  initial begin
    repeat (50000) @(posedge clk);
    errors++;
    end_sim();
  end
  ////////////////////////////////////////////////////////////
  // sign extension from n significant bits
  function automatic logic [15:0] sx(input logic [15:0] v, input int n);
    logic signed [15:0] t;
    t = v << (16 - n);
    return t >>> (16 - n);
  endfunction : sx
  // expected condition byte
  function automatic logic [7:0] cb(input logic act, input logic ovr);
    return {act, condIn.watchActive, condIn.fuseOn, 3'h1, condIn.clkGated, ovr};
  endfunction : cb
  // note cnt result bytes, x low first
  task automatic expAxes(input asr_pkg::asr_axes_t v, input int n, input int cnt);
    logic [5:0][7:0] s;
    s = {sx(v.z, n), sx(v.y, n), sx(v.x, n)};
    for (int i = 0; i < cnt; i++) expQ.push_back(s[i]);
  endtask : expAxes
  // burst read from offset
  task automatic rd(input logic [5:0] ofs, input int n);
    host.xfer({2'h2, ofs}, n, 8'h00);
    repeat (4) @(posedge clk);
  endtask : rd
  // new random sample, one-cycle strobe
  task automatic putSample(output asr_pkg::asr_axes_t v);
    v = {16'($random(seed)), 16'($random(seed)), 16'($random(seed))};
    @(posedge clk);
    sampleIn <= v;
    sampleValid <= 1'b1;
    @(posedge clk);
    sampleValid <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : putSample
  // one two-wire bit, 500 ns per phase; q is the line in the high phase
  task automatic twBit(input logic d, output logic q);
    sdaM <= d;
    repeat (5) @(posedge clk);
    scl <= 1'b1;
    repeat (3) @(posedge clk);
    q = sdaM && !sdaOe;
    repeat (2) @(posedge clk);
    scl <= 1'b0;
    repeat (5) @(posedge clk);
  endtask : twBit
  // eight bits msb first, then the ack bit
  task automatic twByte(input logic [7:0] d, input logic ai, output logic [7:0] q, output logic ao);
    for (int i = 7; i >= 0; i--) twBit(d[i], q[i]);
    twBit(ai, ao);
  endtask : twByte
  // start (s=1) or stop (s=0) on the two-wire bus
  task automatic twCond(input logic s);
    sdaM <= s;
    repeat (5) @(posedge clk);
    scl <= 1'b1;
    repeat (5) @(posedge clk);
    sdaM <= !s;
    repeat (5) @(posedge clk);
    scl <= !s;
    repeat (5) @(posedge clk);
  endtask : twCond
  task automatic end_sim();
    if (errors == 0 && samplesChecked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  ////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    sys_rst = 1'b1;
    addrStrapPin = 1'b1;
    twoWireEn = 1'b0;
    spiEn = 1'b0;
    fifoEn = 1'b0;
    sampleValid = 1'b0;
    activityEvent = 1'b0;
    sampleIn = '0;
    fifoHead = '0;
    condIn = '0;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (8) @(posedge clk);
    spiEn <= 1'b1;
    addrStrapPin <= 1'b0;
    condIn <= 3'($random(seed));
    repeat (4) @(posedge clk);
    expQ.push_back(8'h08);
    expQ.push_back(cb(1'b0, 1'b0));
    expAxes('0, 14, 6);
    expQ.push_back(8'h00);
    rd(6'h00, 9);
    host.xfer(8'h00, 2, 8'hFF);
    expQ.push_back(8'h08);
    expQ.push_back(cb(1'b0, 1'b0));
    rd(6'h00, 2);
    for (int k = 0; k < 3; k++) begin
      condIn <= 3'($random(seed));
      putSample(a);
      putSample(a);
      expQ.push_back(cb(1'b0, 1'b1));
      rd(6'h01, 1);
      expAxes(a, 14, 6);
      rd(6'h02, 6);
      putSample(a);
      expQ.push_back(cb(1'b0, 1'b0));
      expAxes(a, 14, 6);
      rd(6'h01, 7);
    end
    @(posedge clk);
    activityEvent <= 1'b1;
    @(posedge clk);
    activityEvent <= 1'b0;
    #1 `CHK({modeReqValid, modeReqCode}, {1'b1, asr_pkg::MODE_CONT})
    repeat (3) @(posedge clk);
    expQ.push_back(cb(1'b1, 1'b0));
    rd(6'h01, 1);
    h = {16'($random(seed)), 16'($random(seed)), 16'($random(seed))};
    fifoEn <= 1'b1;
    fifoHead <= h;
    repeat (4) @(posedge clk);
    a0 = advCount;
    expAxes(h, 12, 6);
    rd(6'h02, 6);
    for (int i = 0; i < 20 && advCount == a0; i++) @(posedge clk);
    `CHK(advCount, a0 + 1)
    expAxes(h, 12, 4);
    rd(6'h02, 4);
    repeat (8) @(posedge clk);
    `CHK(advCount, a0 + 1)
    fifoEn <= 1'b0;
    spiEn <= 1'b0;
    putSample(b);
    spiEn <= 1'b1;
    repeat (4) @(posedge clk);
    expAxes(h, 12, 6);
    rd(6'h02, 6);
    // sample lands while a frame is open
    expAxes(h, 12, 6);
    fork
      rd(6'h02, 6);
      putSample(b);
    join
    expAxes(b, 14, 6);
    rd(6'h02, 6);
    // two-wire: wrong address ignored, then pointer and burst read
    twoWireEn <= 1'b1;
    spiEn <= 1'b0;
    expAxes(b, 14, 6);
    twCond(1'b1);
    twByte({asr_pkg::BUS_ADDR_LOW, 1'b0}, 1'b1, twRx, ack);
    `CHK(ack, 1'b1)
    twCond(1'b1);
    twByte({asr_pkg::BUS_ADDR_HIGH, 1'b0}, 1'b1, twRx, ack);
    `CHK(ack, 1'b0)
    twByte(asr_pkg::X_LOW_OFS, 1'b1, twRx, ack);
    `CHK(ack, 1'b0)
    twCond(1'b1);
    twByte({asr_pkg::BUS_ADDR_HIGH, 1'b1}, 1'b1, twRx, ack);
    `CHK(ack, 1'b0)
    for (int i = 0; i < 6; i++) begin
      twByte(8'hFF, i == 5, twRx, ack);
      twStb = 1'b1;
      #1 twStb = 1'b0;
    end
    twCond(1'b0);
    repeat (10) @(posedge clk);
    `CHK(expQ.size(), 0)
    end_sim();
  end
endmodule : asr_status_regs_tb_top
`default_nettype wire
